//--- rtl/amp_out_consts.svh
`ifndef AMP_OUT_CONSTS_SVH
`define AMP_OUT_CONSTS_SVH
`define A_FLTR 8'h03
`define A_FMT 8'h04
`define A_MVOL 8'h07
`define A_RAMP 8'h0c
`define A_PATH 8'h14
`define A_SPKG 8'h1a
`define A_COEF0 8'h21
`define A_COEF1 8'h22
`define A_MIX1 8'h53
`define A_CLIP 8'h62
`define A_TAP 8'h73
`define A_DC 8'h76
`define A_BRG 8'h84
`define A_LVL_L 8'hb0
`define A_LVL_R 8'hb1
`define M_FLTR 8'hd9
`define M_FMT 8'h0f
`define M_SPKG 8'h70
`define M_COEF0 32'hffff07ff
`define M_COEF1 32'h07ff01ff
`define M_MIX 64'h03ffffff03ffffff
`define M_CLIP 32'hc007ffff
`define M_TAP 8'h70
`define M_DC 8'h37
`define M_BRG 8'h07
`define R_FLTR 8'h80
`define R_FMT 8'h05
`define R_MVOL 11'h7ff
`define R_RAMP 8'h01
`define R_PATH 8'hff
`define R_CLIP 32'h00018080
`define R_DC 8'h04
`define B_COMP_EN 4
`define B_CLIP_EN 31
`define B_FCLIP_EN 30
`define B_DC_DETECTED_FLAG 7
`define B_DC_CLK 2
`define B_DC_TIME 1
`define B_DC_PROTECT_CONTROL 0
`define B_PARALLEL 2
`define B_SKIP_RAMP 3
`define VOL_MUTE 11'h7ff
`define VOL_M40 11'h400
`define TAP_EQ 3'h1
`define TAP_GAIN 3'h2
`define TAP_FINAL 3'h3
`define TAP_LEVEL 3'h4
`define CLK_HZ 10000000
`define DC_CLK_HZ 384000
`define DC_DIV (`CLK_HZ / `DC_CLK_HZ)
`define DC_WIN_MS 342
`define DC_WIN_TICKS (`DC_WIN_MS * `DC_CLK_HZ / 1000)
`endif

//--- rtl/amp_out_pkg.sv
`default_nettype none
package amp_out_pkg;
    typedef logic signed [23:0] sample_t;
    typedef logic signed [55:0] wide_t;
    typedef enum logic [3:0] {
        FR_NONE = 4'b0001,
        FR_RIGHT = 4'b0010,
        FR_STD = 4'b0100,
        FR_LEFT = 4'b1000
    } frame_e;
endpackage
`default_nettype wire

//--- rtl/amp_out_stage.sv
`include "amp_out_consts.svh"
`default_nettype none
module amp_out_stage #(
    parameter int unsigned DC_WIN_TICKS = `DC_WIN_TICKS
) (
    // Clock and reset.
    input wire logic REF_CLK,
    input wire logic RST_N,
    // Register port.
    input wire logic REG_WE,
    input wire logic REG_RE,
    input wire logic [7:0] REG_ADDR,
    input wire logic [63:0] REG_WDATA,
    output logic [63:0] REG_RDATA,
    output logic REG_RVALID,
    // Audio in.
    input wire logic IN_VALID,
    output logic IN_READY,
    input wire amp_out_pkg::sample_t IN_LEFT,
    input wire amp_out_pkg::sample_t IN_RIGHT,
    // Audio out toward the power stage.
    output logic OUT_VALID,
    input wire logic OUT_READY,
    output amp_out_pkg::sample_t OUT_LEFT,
    output amp_out_pkg::sample_t OUT_RIGHT,
    // Serial data tap.
    output logic TAP_VALID,
    output amp_out_pkg::sample_t TAP_LEFT,
    output amp_out_pkg::sample_t TAP_RIGHT,
    // Power stage control and monitor.
    input wire logic [1:0] PWM_MON,
    output logic AMP_SHUTDOWN,
    output logic [7:0] PATH_EN,
    output logic PARALLEL_BRIDGE,
    output logic [4:0] NOISE_KHZ,
    output logic [9:0] SPK_GAIN_X100,
    output logic [12:0] PEAK_SCALE_X200,
    // Decoded serial format.
    output var amp_out_pkg::frame_e FRAME_ALIGN,
    output logic [4:0] WORD_BITS
);
    import amp_out_pkg::*;

    logic [7:0] fltr_q, fmt_q, ramp_q, path_q, spkg_q, tap_q, dcc_q, brg_q;
    logic [10:0] mvol_q, vol_q;
    logic [31:0] coef0_q, coef1_q, clip_q;
    logic [63:0] mix_q;
    logic dc_detected_flag_q, dc_trip, accept, left_ok, right_ok, step_last, below_m40;
    logic [2:0] ramp_cnt_q;
    logic [1:0] ramp_sh;
    logic [16:0] lin_vol;
    wide_t clip_thr, acc;
    sample_t mono, pre_vol, fir_v;
    sample_t din [2];
    sample_t eq_w [2];
    sample_t vol_w [2];
    sample_t fin_w [2];
    sample_t hist_q [2][6];
    logic [47:0] ms_q [2];
    logic [31:0] lvl_q [2];

    // Mantissa of 2^(-k/8) in steps of 0.75 dB, then one shift per 6 dB.
    function automatic logic [16:0] db_lin(input logic [10:0] c);
        logic [16:0] m;
        case (4'(c % 11'd96 / 11'd12))
            4'h0: m = 17'd65536;
            4'h1: m = 17'd60097;
            4'h2: m = 17'd55109;
            4'h3: m = 17'd50535;
            4'h4: m = 17'd46341;
            4'h5: m = 17'd42495;
            4'h6: m = 17'd38968;
            default: m = 17'd35734;
        endcase
        return (c == `VOL_MUTE) ? 17'h0 : m >> (c / 11'd96);
    endfunction

    function automatic sample_t sat24(input wide_t v);
        if (v > wide_t'(24'sh7fffff)) return 24'sh7fffff;
        if (v < wide_t'(-24'sh7fffff)) return -24'sh7fffff;
        return sample_t'(v);
    endfunction

    function automatic sample_t clip(input sample_t v, input wide_t t);
        if (wide_t'(v) > t) return sample_t'(t);
        if (wide_t'(v) < -t) return sample_t'(-t);
        return v;
    endfunction

    function automatic logic [23:0] isqrt(input logic [47:0] v);
        logic [23:0] q;
        logic [23:0] t;
        q = 24'h0;
        for (int i = 23; i >= 0; i--) begin
            t = q | (24'h1 << i);
            if (48'(t) * 48'(t) <= v) q = t;
        end
        return q;
    endfunction

    assign accept = IN_VALID && IN_READY;
    assign left_ok = path_q[6] && path_q[4] && path_q[2] && path_q[0] && !dc_detected_flag_q;
    assign right_ok = path_q[7] && path_q[5] && path_q[3] && path_q[1] && !dc_detected_flag_q;

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            fltr_q <= `R_FLTR;
            fmt_q <= `R_FMT;
            mvol_q <= `R_MVOL;
            ramp_q <= `R_RAMP;
            path_q <= `R_PATH;
            spkg_q <= 8'h0;
            coef0_q <= 32'h0;
            coef1_q <= 32'h0;
            mix_q <= 64'h0;
            clip_q <= `R_CLIP;
            tap_q <= 8'h0;
            dcc_q <= `R_DC;
            brg_q <= 8'h0;
        end else if (REG_WE) begin
            case (REG_ADDR)
                `A_FLTR: fltr_q <= REG_WDATA[7:0] & `M_FLTR;
                `A_FMT: fmt_q <= REG_WDATA[7:0] & `M_FMT;
                `A_MVOL: mvol_q <= REG_WDATA[10:0];
                `A_RAMP: ramp_q <= REG_WDATA[7:0];
                `A_PATH: path_q <= REG_WDATA[7:0];
                `A_SPKG: spkg_q <= REG_WDATA[7:0] & `M_SPKG;
                `A_COEF0: coef0_q <= REG_WDATA[31:0] & `M_COEF0;
                `A_COEF1: coef1_q <= REG_WDATA[31:0] & `M_COEF1;
                `A_MIX1: mix_q <= REG_WDATA & `M_MIX;
                `A_CLIP: clip_q <= REG_WDATA[31:0] & `M_CLIP;
                `A_TAP: tap_q <= REG_WDATA[7:0] & `M_TAP;
                `A_DC: dcc_q <= REG_WDATA[7:0] & `M_DC;
                `A_BRG: brg_q <= REG_WDATA[7:0] & `M_BRG;
                default: ;
            endcase
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            REG_RDATA <= 64'h0;
            REG_RVALID <= 1'b0;
        end else begin
            REG_RVALID <= REG_RE;
            if (REG_RE) begin
                case (REG_ADDR)
                    `A_FLTR: REG_RDATA <= 64'(fltr_q);
                    `A_FMT: REG_RDATA <= 64'(fmt_q);
                    `A_MVOL: REG_RDATA <= 64'(mvol_q);
                    `A_RAMP: REG_RDATA <= 64'(ramp_q);
                    `A_PATH: REG_RDATA <= 64'(path_q);
                    `A_SPKG: REG_RDATA <= 64'(spkg_q);
                    `A_COEF0: REG_RDATA <= 64'(coef0_q);
                    `A_COEF1: REG_RDATA <= 64'(coef1_q);
                    `A_MIX1: REG_RDATA <= mix_q;
                    `A_CLIP: REG_RDATA <= 64'(clip_q);
                    `A_TAP: REG_RDATA <= 64'(tap_q);
                    `A_DC: REG_RDATA <= 64'({dc_detected_flag_q, dcc_q[6:0]});
                    `A_BRG: REG_RDATA <= 64'(brg_q);
                    `A_LVL_L: REG_RDATA <= 64'(lvl_q[0]);
                    `A_LVL_R: REG_RDATA <= 64'(lvl_q[1]);
                    default: REG_RDATA <= 64'h0;
                endcase
            end
        end
    end

    // Sample path: mix, post gain, clip, volume, compensation, final clip.
    always_comb begin
        lin_vol = db_lin(vol_q);
        clip_thr = wide_t'(db_lin(clip_q[18:8])) <<< 11;
        acc = '0;
        pre_vol = '0;
        fir_v = '0;
        mono = sat24((wide_t'(IN_LEFT) * wide_t'(signed'(mix_q[57:32]))
                    + wide_t'(IN_RIGHT) * wide_t'(signed'(mix_q[25:0]))) >>> 23);
        din[0] = brg_q[`B_PARALLEL] ? mono : IN_LEFT;
        din[1] = brg_q[`B_PARALLEL] ? mono : IN_RIGHT;
        for (int c = 0; c < 2; c++) begin
            eq_w[c] = sat24((wide_t'(din[c]) * wide_t'(signed'({1'b0, clip_q[7:0]}))) >>> 7);
            pre_vol = clip_q[`B_CLIP_EN] ? clip(eq_w[c], clip_thr) : eq_w[c];
            vol_w[c] = sat24((wide_t'(pre_vol) * wide_t'(signed'({1'b0, lin_vol}))) >>> 12);
            acc = wide_t'(signed'(coef1_q[8:0])) * (wide_t'(vol_w[c]) + wide_t'(hist_q[c][5]))
                + wide_t'(signed'(coef1_q[26:16])) * (wide_t'(hist_q[c][0]) + wide_t'(hist_q[c][4]))
                + wide_t'(signed'(coef0_q[10:0])) * (wide_t'(hist_q[c][1]) + wide_t'(hist_q[c][3]))
                + wide_t'(signed'(coef0_q[31:16])) * wide_t'(hist_q[c][2]);
            fir_v = fltr_q[`B_COMP_EN] ? sat24(acc >>> 14) : vol_w[c];
            fir_v = clip_q[`B_FCLIP_EN] ? clip(fir_v, clip_thr) : fir_v;
            fin_w[c] = ((c == 0) ? left_ok : right_ok) ? fir_v : '0;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            for (int c = 0; c < 2; c++) begin
                for (int k = 0; k < 6; k++) hist_q[c][k] <= '0;
                ms_q[c] <= 48'h0;
                lvl_q[c] <= 32'h0;
            end
        end else if (accept) begin
            for (int c = 0; c < 2; c++) begin
                hist_q[c][0] <= vol_w[c];
                for (int k = 1; k < 6; k++) hist_q[c][k] <= hist_q[c][k-1];
                ms_q[c] <= ms_q[c] + (48'(wide_t'(fin_w[c]) * wide_t'(fin_w[c])) >> 8) - (ms_q[c] >> 8);
                lvl_q[c] <= 32'(isqrt(ms_q[c]));
            end
        end
    end

    // Step interval is a power of two; below -40 dB it is halved, except in mode 0.
    assign below_m40 = vol_q > `VOL_M40;
    always_comb begin
        case (ramp_q[2:0])
            3'h0: ramp_sh = 2'd0;
            3'h1: ramp_sh = below_m40 ? 2'd0 : 2'd1;
            3'h2: ramp_sh = below_m40 ? 2'd1 : 2'd2;
            default: ramp_sh = below_m40 ? 2'd2 : 2'd3;
        endcase
    end
    assign step_last = ramp_cnt_q == 3'((4'h1 << ramp_sh) - 4'h1);

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            vol_q <= `VOL_MUTE;
            ramp_cnt_q <= 3'h0;
        end else if (ramp_q[`B_SKIP_RAMP]) begin
            vol_q <= mvol_q;
            ramp_cnt_q <= 3'h0;
        end else if (accept) begin
            if (vol_q == mvol_q) begin
                ramp_cnt_q <= 3'h0;
            end else if (step_last) begin
                vol_q <= (vol_q < mvol_q) ? vol_q + 11'h1 : vol_q - 11'h1;
                ramp_cnt_q <= 3'h0;
            end else begin
                ramp_cnt_q <= ramp_cnt_q + 3'h1;
            end
        end
    end

    // Two-entry buffer: output register plus one skid entry.
    logic skid_v_q;
    sample_t skid_l_q, skid_r_q;
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            OUT_VALID <= 1'b0;
            OUT_LEFT <= '0;
            OUT_RIGHT <= '0;
            skid_v_q <= 1'b0;
            skid_l_q <= '0;
            skid_r_q <= '0;
            IN_READY <= 1'b0;
        end else begin
            IN_READY <= 1'b1;
            if (!OUT_VALID || OUT_READY) begin
                OUT_VALID <= skid_v_q || accept;
                OUT_LEFT <= skid_v_q ? skid_l_q : fin_w[0];
                OUT_RIGHT <= skid_v_q ? skid_r_q : fin_w[1];
                skid_v_q <= skid_v_q && accept;
                skid_l_q <= fin_w[0];
                skid_r_q <= fin_w[1];
                IN_READY <= 1'b1;
            end else if (accept) begin
                skid_v_q <= 1'b1;
                skid_l_q <= fin_w[0];
                skid_r_q <= fin_w[1];
                IN_READY <= 1'b0;
            end else begin
                IN_READY <= !skid_v_q;
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            TAP_VALID <= 1'b0;
            TAP_LEFT <= '0;
            TAP_RIGHT <= '0;
        end else begin
            TAP_VALID <= 1'b0;
            if (accept) begin
                TAP_VALID <= tap_q[6:4] >= `TAP_EQ && tap_q[6:4] <= `TAP_LEVEL;
                case (tap_q[6:4])
                    `TAP_EQ: {TAP_LEFT, TAP_RIGHT} <= {eq_w[0], eq_w[1]};
                    `TAP_GAIN: {TAP_LEFT, TAP_RIGHT} <= {vol_w[0], vol_w[1]};
                    `TAP_FINAL: {TAP_LEFT, TAP_RIGHT} <= {fin_w[0], fin_w[1]};
                    `TAP_LEVEL: {TAP_LEFT, TAP_RIGHT} <= {sample_t'(lvl_q[0]), sample_t'(lvl_q[1])};
                    default: {TAP_LEFT, TAP_RIGHT} <= '0;
                endcase
            end
        end
    end

    // DC detection on a 384 kHz tick; pins pass two flip-flops first.
    logic [1:0] pwm_s1_q, pwm_s2_q;
    logic [4:0] div_q;
    logic [19:0] win_q, win_len, dev_thr;
    logic [19:0] ones_q [2];
    logic dc_tick;
    assign dc_tick = div_q == 5'(`DC_DIV - 1);
    assign win_len = dcc_q[`B_DC_TIME] ? 20'(DC_WIN_TICKS * 2) : 20'(DC_WIN_TICKS);
    always_comb begin
        case (dcc_q[5:4])
            2'h1: dev_thr = win_len >> 3;
            2'h2: dev_thr = 20'((21'(win_len) * 21'h3) >> 4);
            2'h3: dev_thr = win_len >> 2;
            default: dev_thr = 20'hfffff;
        endcase
        dc_trip = 1'b0;
        for (int c = 0; c < 2; c++) begin
            if ((ones_q[c] > win_len - ones_q[c] ? ones_q[c] * 2 - win_len : win_len - ones_q[c] * 2) > dev_thr)
                dc_trip = 1'b1;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            pwm_s1_q <= 2'h0;
            pwm_s2_q <= 2'h0;
            div_q <= 5'h0;
            win_q <= 20'h0;
            ones_q[0] <= 20'h0;
            ones_q[1] <= 20'h0;
            dc_detected_flag_q <= 1'b0;
        end else begin
            pwm_s1_q <= PWM_MON;
            pwm_s2_q <= pwm_s1_q;
            div_q <= dc_tick ? 5'h0 : div_q + 5'h1;
            if (REG_WE && REG_ADDR == `A_DC && REG_WDATA[`B_DC_DETECTED_FLAG])
                dc_detected_flag_q <= 1'b0;
            if (!dcc_q[`B_DC_PROTECT_CONTROL]) begin
                win_q <= 20'h0;
                ones_q[0] <= 20'h0;
                ones_q[1] <= 20'h0;
            end else if (dc_tick) begin
                // A window shortened while it runs still ends at once.
                if (win_q >= win_len - 20'h1) begin
                    win_q <= 20'h0;
                    ones_q[0] <= 20'h0;
                    ones_q[1] <= 20'h0;
                    if (dc_trip) dc_detected_flag_q <= 1'b1;
                end else begin
                    win_q <= win_q + 20'h1;
                    ones_q[0] <= ones_q[0] + 20'(pwm_s2_q[0]);
                    ones_q[1] <= ones_q[1] + 20'(pwm_s2_q[1]);
                end
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            AMP_SHUTDOWN <= 1'b0;
            PATH_EN <= 8'h0;
            PARALLEL_BRIDGE <= 1'b0;
            NOISE_KHZ <= 5'd5;
            SPK_GAIN_X100 <= 10'd300;
            PEAK_SCALE_X200 <= 13'd2100;
            FRAME_ALIGN <= FR_NONE;
            WORD_BITS <= 5'd0;
        end else begin
            AMP_SHUTDOWN <= dc_detected_flag_q;
            PATH_EN <= path_q & {8{!dc_detected_flag_q}};
            PARALLEL_BRIDGE <= brg_q[`B_PARALLEL];
            NOISE_KHZ <= 5'(5'd5 * (5'(brg_q[1:0]) + 5'd1));
            case (spkg_q[6:4])
                3'h0: SPK_GAIN_X100 <= 10'd300;
                3'h1: SPK_GAIN_X100 <= 10'd350;
                3'h2: SPK_GAIN_X100 <= 10'd400;
                3'h3: SPK_GAIN_X100 <= 10'd450;
                3'h4: SPK_GAIN_X100 <= 10'd500;
                3'h5: SPK_GAIN_X100 <= 10'd550;
                3'h6: SPK_GAIN_X100 <= 10'd615;
                default: SPK_GAIN_X100 <= 10'd800;
            endcase
            PEAK_SCALE_X200 <= 13'(SPK_GAIN_X100 * 13'd7);
            WORD_BITS <= (fmt_q > 8'h8) ? 5'd0 : 5'(5'd16 + 5'd4 * 5'(fmt_q % 8'h3));
            if (fmt_q < 8'h3) FRAME_ALIGN <= FR_RIGHT;
            else if (fmt_q < 8'h6) FRAME_ALIGN <= FR_STD;
            else if (fmt_q < 8'h9) FRAME_ALIGN <= FR_LEFT;
            else FRAME_ALIGN <= FR_NONE;
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);

    sequence s_window_trip;
        dcc_q[`B_DC_PROTECT_CONTROL] && dc_tick && win_q >= win_len - 20'h1 && dc_trip;
    endsequence

    a_tap_silent: assert property (accept && (tap_q[6:4] == 3'h0 || tap_q[6:4] > 3'h4) |=> !TAP_VALID)
        else $error("tap output not silent");
    a_tap_final: assert property (accept && tap_q[6:4] == 3'h3 |=> TAP_VALID && TAP_LEFT == $past(fin_w[0]))
        else $error("final tap wrong");
    a_format_std: assert property (fmt_q == 8'h5 |=> WORD_BITS == 5'd24 && FRAME_ALIGN == FR_STD)
        else $error("format decode wrong");
    a_gain_top: assert property (spkg_q[6:4] == 3'h7 |=> SPK_GAIN_X100 == 10'd800 ##1 PEAK_SCALE_X200 == 13'd5600)
        else $error("speaker gain map wrong");
    a_vol_step: assert property (accept && !ramp_q[3] && vol_q != mvol_q && step_last
        |=> vol_q == $past(vol_q) + 11'h1 || vol_q == $past(vol_q) - 11'h1)
        else $error("volume did not step");
    a_vol_hold: assert property (!accept && !ramp_q[3] |=> $stable(vol_q))
        else $error("volume moved without a sample");
    a_dc_trip: assert property (s_window_trip |=> dc_detected_flag_q ##1 AMP_SHUTDOWN && PATH_EN == 8'h0)
        else $error("dc trip did not shut down");
    a_dc_idle: assert property (!dcc_q[`B_DC_PROTECT_CONTROL] |=> win_q == 20'h0)
        else $error("dc detector ran while disabled");
    a_clip_bound: assert property (clip_q[30] && fltr_q[4] == 1'b0 && accept && left_ok
        |-> wide_t'(fin_w[0]) <= clip_thr && wide_t'(fin_w[0]) >= -clip_thr)
        else $error("final clip exceeded");
    a_bypass: assert property (!fltr_q[4] && !clip_q[30] && left_ok |-> fin_w[0] == vol_w[0])
        else $error("bypass path wrong");
endmodule
`default_nettype wire

//--- verif/power_stage_model.sv
`default_nettype none
module power_stage_model (
    // Clock.
    input wire logic clk,
    // Test controls.
    input wire logic stall,
    input wire logic bias,
    // Toward the amplifier stage.
    output logic out_ready,
    output logic [1:0] pwm_mon
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] lfsr_q = 16'hace1;
    logic rdy_q = 1'b0;
    logic [1:0] pwm_q = 2'h0;
    int unsigned phase_q = 0;
    assign out_ready = rdy_q;
    assign pwm_mon = pwm_q;
    // Random back-pressure makes the output hold its data across stalls.
    always @(posedge clk) begin
        lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        rdy_q <= !stall && lfsr_q[0];
    end
    // A balanced duty carries no DC; bias holds both bridges high to fake a DC fault.
    always @(posedge clk) begin
        phase_q <= (phase_q == 51) ? 0 : phase_q + 1;
        pwm_q <= (bias || phase_q < 26) ? 2'h3 : 2'h0;
    end
endmodule
`default_nettype wire

//--- verif/tb_top.sv
`include "amp_out_consts.svh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import amp_out_pkg::*;
    logic clk, ordy, rv, in_rdy, ov, tv, sd, pb;
    logic rst_n = 0, we = 0, re = 0, iv = 0, stall = 0, bias = 0, zero_mode = 0, dly = 0, clp = 0;
    logic [7:0] addr = 0, pe;
    logic [63:0] wd = 0, rdat;
    sample_t il = 0, ir_s = 0, ol, or_s, tl, tr;
    logic [1:0] pwm;
    logic [4:0] nk, wb;
    logic [9:0] sg;
    logic [12:0] ps;
    frame_e fa;
    logic [31:0] seed = 32'h3f9325aa;
    logic [2:0][47:0] hist = '0;
    logic [47:0] exp_q[$];
    int fail_count = 0, checks = 0, taps = 0;
    amp_out_stage #(.DC_WIN_TICKS(16)) i_dut (
        .REF_CLK(clk), .RST_N(rst_n), .REG_WE(we), .REG_RE(re), .REG_ADDR(addr), .REG_WDATA(wd),
        .REG_RDATA(rdat), .REG_RVALID(rv), .IN_VALID(iv), .IN_READY(in_rdy), .IN_LEFT(il),
        .IN_RIGHT(ir_s), .OUT_VALID(ov), .OUT_READY(ordy), .OUT_LEFT(ol), .OUT_RIGHT(or_s),
        .TAP_VALID(tv), .TAP_LEFT(tl), .TAP_RIGHT(tr), .PWM_MON(pwm), .AMP_SHUTDOWN(sd),
        .PATH_EN(pe), .PARALLEL_BRIDGE(pb), .NOISE_KHZ(nk), .SPK_GAIN_X100(sg),
        .PEAK_SCALE_X200(ps), .FRAME_ALIGN(fa), .WORD_BITS(wb));
    power_stage_model i_partner (.clk(clk), .stall(stall), .bias(bias), .out_ready(ordy), .pwm_mon(pwm));
    initial begin
        clk = 0;
        forever #50 clk = ~clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [8:0] fmt_exp(input int c);
        frame_e f;
        f = c < 3 ? FR_RIGHT : c < 6 ? FR_STD : c < 9 ? FR_LEFT : FR_NONE;
        return {f, c < 9 ? 5'(16 + 4 * (c % 3)) : 5'd0};
    endfunction
    function automatic sample_t lim(input sample_t v);
        return v > 24'sh400000 ? 24'sh400000 : v < -24'sh400000 ? -24'sh400000 : v;
    endfunction
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [63:0] d);
        @(negedge clk);
        we = 1;
        addr = a;
        wd = d;
        @(negedge clk);
        we = 0;
        repeat (2) @(negedge clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [63:0] d);
        @(negedge clk);
        re = 1;
        addr = a;
        @(negedge clk);
        re = 0;
        chk(rv, 1);
        d = rdat;
    endtask
    // The filter history follows every accepted pair, so it is tracked here too.
    task automatic stream(input int cnt);
        int k;
        for (int i = 0; i < cnt; i++) begin
            @(negedge clk);
            seed = lfsr(seed);
            iv = 1;
            il = seed[23:0];
            ir_s = {seed[7:0], seed[31:16]};
            k = 0;
            while (in_rdy !== 1'b1 && k < 200) begin
                @(negedge clk);
                k++;
            end
            exp_q.push_back(zero_mode ? 48'h0 : dly ? hist[2] : clp ? {lim(il), lim(ir_s)} : {il, ir_s});
            hist = {hist[1:0], il, ir_s};
        end
        @(negedge clk);
        iv = 0;
    endtask
    task automatic drain();
        int k;
        k = 0;
        while (exp_q.size() != 0 && k < 500) begin
            @(negedge clk);
            k++;
        end
        chk(exp_q.size(), 0);
        repeat (3) @(negedge clk);
    endtask
    always @(posedge clk) begin
        if (rst_n && ov === 1'b1 && ordy === 1'b1) begin
            chk({ol, or_s}, exp_q.size() != 0 ? exp_q.pop_front() : 48'hx);
        end
        if (tv === 1'b1) begin
            taps++;
        end
    end
    initial begin
        logic [63:0] v;
        int cnt, tgt;
        logic [7:0] ra[9] = '{`A_FLTR, `A_FMT, `A_MVOL, `A_RAMP, `A_PATH, `A_CLIP, `A_DC, `A_LVL_L, `A_LVL_R};
        logic [31:0] rr[9] = '{`R_FLTR, `R_FMT, `R_MVOL, `R_RAMP, `R_PATH, `R_CLIP, `R_DC, 0, 0};
        logic [7:0] ma[6] = '{`A_COEF0, `A_COEF1, 8'h99, `A_TAP, `A_BRG, `A_SPKG};
        logic [31:0] mm[6] = '{`M_COEF0, `M_COEF1, 0, `M_TAP, `M_BRG, `M_SPKG};
        logic [9:0] gt[8] = '{10'd300, 10'd350, 10'd400, 10'd450, 10'd500, 10'd550, 10'd615, 10'd800};
        repeat (3) @(negedge clk);
        rst_n = 1;
        for (int i = 0; i < 9; i++) begin
            rd(ra[i], v);
            chk(v, rr[i]);
        end
        for (int i = 0; i < 6; i++) begin
            wr(ma[i], '1);
            rd(ma[i], v);
            chk(v, mm[i]);
        end
        $display("test registers done");
        for (int c = 0; c < 8; c++) begin
            wr(`A_SPKG, 64'(c << 4));
            chk(sg, gt[c]);
            chk(ps, gt[c] * 7);
            wr(`A_BRG, 64'(c));
            chk(pb, c[2]);
            chk(nk, 5 * (c % 4 + 1));
        end
        wr(`A_BRG, 0);
        for (int c = 0; c < 10; c++) begin
            wr(`A_FMT, 64'(c));
            chk({fa, wb}, fmt_exp(c));
        end
        seed = lfsr(seed);
        wr(`A_PATH, 64'(seed[7:0]));
        chk(pe, seed[7:0]);
        wr(`A_PATH, 64'hff);
        $display("test config done");
        wr(`A_MVOL, 64'h180);
        wr(`A_RAMP, 64'h08);
        for (int c = 0; c < 6; c++) begin
            wr(`A_TAP, 64'(c << 4));
            taps = 0;
            stream(6);
            drain();
            chk(taps, (c >= 1 && c <= 4) ? 6 : 0);
        end
        $display("test tap done");
        rd(`A_LVL_L, v);
        chk(v != 0 && v < 64'h800000, 1);
        rd(`A_LVL_R, v);
        chk(v != 0 && v < 64'h800000, 1);
        wr(`A_COEF0, 64'h40000000);
        wr(`A_COEF1, 0);
        wr(`A_FLTR, 64'h10);
        dly = 1;
        stream(8);
        drain();
        dly = 0;
        wr(`A_FLTR, `R_FLTR);
        $display("test filter done");
        zero_mode = 1;
        wr(`A_CLIP, 64'h00018000);
        stream(4);
        drain();
        wr(`A_CLIP, `R_CLIP);
        wr(`A_MVOL, `VOL_MUTE);
        stream(4);
        drain();
        wr(`A_MVOL, 64'h180);
        wr(`A_CLIP, 64'h00018000);
        for (int m = 0; m < 4; m++) begin
            tgt = 'h180 + 16 * (m + 1);
            wr(`A_RAMP, 64'(m));
            wr(`A_MVOL, 64'(tgt));
            stream((16 << m) - 1);
            chk(i_dut.vol_q == 11'(tgt), 0);
            stream(1);
            chk(i_dut.vol_q, 64'(tgt));
        end
        drain();
        wr(`A_RAMP, 64'h08);
        wr(`A_MVOL, 64'h180);
        wr(`A_CLIP, `R_CLIP);
        zero_mode = 0;
        clp = 1;
        wr(`A_CLIP, 64'h8001e080);
        stream(8);
        drain();
        wr(`A_CLIP, 64'h4001e080);
        stream(8);
        drain();
        clp = 0;
        wr(`A_CLIP, `R_CLIP);
        $display("test mute done");
        stall = 1;
        fork
            stream(3);
            begin
                repeat (12) @(negedge clk);
                chk(in_rdy, 0);
                chk(exp_q.size(), 2);
                stall = 0;
            end
        join
        drain();
        $display("test buffer done");
        bias = 1;
        repeat (1000) @(negedge clk);
        chk(sd, 0);
        wr(`A_DC, 64'h37);
        cnt = 2;
        while (sd !== 1'b1 && cnt < 3000) begin
            @(negedge clk);
            cnt++;
        end
        chk(cnt >= 800 && cnt <= 900, 1);
        chk(pe, 0);
        rd(`A_DC, v);
        chk(v, 64'hb7);
        wr(`A_DC, 64'hb4);
        chk(sd, 0);
        rd(`A_DC, v);
        chk(v, 64'h34);
        wr(`A_DC, 64'h35);
        cnt = 2;
        while (sd !== 1'b1 && cnt < 3000) begin
            @(negedge clk);
            cnt++;
        end
        chk(cnt >= 380 && cnt <= 440, 1);
        $display("test dc done");
        conclude();
    end
    initial begin
        #3000000;
        fail_count++;
        conclude();
    end
    task automatic conclude();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
endmodule
`default_nettype wire
